// file: design/bel_pkg.sv
// Package with constants and types for the boot and lane configuration block
package bel_pkg;

  // Boot mode strap encoding (integrator defined)
  localparam logic [1:0] BOOT_HOST_CODE  = 2'h0;
  localparam logic [1:0] BOOT_EMU_CODE   = 2'h1;
  localparam logic [1:0] BOOT_ROM_CODE   = 2'h2;

  // ROM width strap encoding
  localparam logic [1:0] ROM_W8_CODE     = 2'h0;
  localparam logic [1:0] ROM_W16_CODE    = 2'h1;
  localparam logic [1:0] ROM_W32_CODE    = 2'h2;

  // Memory access width codes
  localparam logic [1:0] ACC_W8          = 2'h0;
  localparam logic [1:0] ACC_W16         = 2'h1;
  localparam logic [1:0] ACC_W32         = 2'h2;

  // Boot copy size and destination
  localparam int         ROM_COPY_BYTES  = 1024;
  localparam logic [31:0] BOOT_DEST_ADDR = 32'h0000_0000;
  localparam logic [31:0] START_ADDR     = 32'h0000_0000;

  // Configuration values loaded in reset and held until the straps are latched
  localparam logic       ENDIAN_RESET    = 1'h1;
  localparam logic       LANE_CORR_RESET = 1'h1;

  // APB register map
  localparam logic [7:0] CTRL_OFFSET     = 8'h00;
  localparam logic [7:0] STATUS_OFFSET   = 8'h04;
  localparam logic [7:0] CONFIG_OFFSET   = 8'h08;
  localparam int         HOSTINT_BIT     = 0;
  localparam int         CPUCLR_BIT      = 1;

  typedef enum logic [4:0] {
    ST_RESET = 5'b00001,
    ST_HOLD  = 5'b00010,
    ST_COPY  = 5'b00100,
    ST_WAIT  = 5'b01000,
    ST_RUN   = 5'b10000
  } bel_state_type;

endpackage : bel_pkg

// file: design/bel_boot_lane.sv
// Boot release control and external data lane placement
//
// Function
// - Endian strap high selects little-endian; default little-endian.
// - Correction strap high: narrow data low lanes little, top lanes big.
// - Correction strap low: narrow data always on lowest lanes.
// - Reset input high keeps internal reset and defined state.
// - On reset release, run with latched configuration and boot mode.
// - Three boot methods: host, emulator, ROM copy.
// - Host boot holds CPU stalled, other units free for host loading.
// - Bit while stalled is not pending interrupt; releases in host and emulator boot.
// - During host boot host may read and write all memory.
// - CPU clears bit after release; no further such interrupts until then.
// - ROM boot copies 1K bytes from chip enable one to zero.
// - Narrow ROM bytes or halfwords are packed into 32-bit words.
// - Copy is one block transfer; completion releases CPU at zero.
`timescale 1ns/1ps
module bel_boot_lane #(
  parameter int ROM_BYTES = bel_pkg::ROM_COPY_BYTES
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        endian_select_strap,
  input  wire logic        lane_correction_strap,
  input  wire logic [1:0]  boot_mode_strap,
  input  wire logic [1:0]  rom_width_strap,
  input  wire logic        host_to_cpu_set,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             cpu_stall,
  output logic             cpu_start,
  output logic [31:0]      cpu_start_addr,
  output logic             cpu_int_pending,
  output logic             host_mem_access,
  output logic             little_order_mode,
  output logic             narrow_lane_correction,
  output logic             rom_rd_req,
  output logic [31:0]      rom_rd_addr,
  input  wire logic        rom_rd_valid,
  input  wire logic [31:0] rom_rd_data,
  output logic             mem_wr_req,
  output logic [31:0]      mem_wr_addr,
  output logic [31:0]      mem_wr_data,
  input  wire logic [1:0]  acc_width,
  input  wire logic [31:0] core_wr_data,
  output logic [31:0]      external_data_lanes,
  output logic [3:0]       lane_strobe
);

  ////////////////////////////////////////////////////////////////////////////
  // Strap synchronisers and configuration latch

  logic [5:0] strap_meta;
  logic [5:0] strap_sync;
  logic [1:0] boot_mode;
  logic [1:0] rom_width;
  logic       cfg_valid;
  logic       rst_seen;

  // No reset here, so the straps are already settled when reset lets go
  always_ff @(posedge clk) begin
    strap_meta <= {rom_width_strap, boot_mode_strap,
                   lane_correction_strap, endian_select_strap};
    strap_sync <= strap_meta;
  end

  // Straps keep being sampled until the first settled cycle after release
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rst_seen               <= 1'b0;
      cfg_valid              <= 1'b0;
      little_order_mode      <= bel_pkg::ENDIAN_RESET;
      narrow_lane_correction <= bel_pkg::LANE_CORR_RESET;
      boot_mode              <= bel_pkg::BOOT_HOST_CODE;
      rom_width              <= bel_pkg::ROM_W32_CODE;
    end else begin
      rst_seen <= 1'b1;
      if (rst_seen && !cfg_valid) begin
        cfg_valid              <= 1'b1;
        little_order_mode      <= strap_sync[0];
        narrow_lane_correction <= strap_sync[1];
        boot_mode              <= strap_sync[3:2];
        rom_width              <= strap_sync[5:4];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Host-to-CPU interrupt bit

  logic host_to_cpu_interrupt;
  logic cpu_clear;
  logic apb_wr;

  assign apb_wr = psel && penable && pwrite;
  assign cpu_clear = apb_wr && (paddr == bel_pkg::CTRL_OFFSET)
                     && pwdata[bel_pkg::CPUCLR_BIT];

  bel_pkg::bel_state_type state;

  // Set beats clear; while set further raises are absorbed
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      host_to_cpu_interrupt <= 1'b0;
    end else if (host_to_cpu_set || (apb_wr && (paddr == bel_pkg::CTRL_OFFSET)
                 && pwdata[bel_pkg::HOSTINT_BIT])) begin
      host_to_cpu_interrupt <= 1'b1;
    end else if (cpu_clear) begin
      host_to_cpu_interrupt <= 1'b0;
    end
  end

  // Pending CPU interrupt only on a fresh rise while running
  logic hint_q;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hint_q          <= 1'b0;
      cpu_int_pending <= 1'b0;
    end else begin
      hint_q <= host_to_cpu_interrupt;
      if (host_to_cpu_interrupt && !hint_q && state == bel_pkg::ST_RUN) begin
        cpu_int_pending <= 1'b1;
      end else if (cpu_clear) begin
        cpu_int_pending <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Boot sequencer

  localparam int WORDS = ROM_BYTES / 4;
  logic [31:0] src_addr;
  logic [31:0] dst_addr;
  logic [31:0] pack;
  logic [1:0]  part;
  logic [1:0]  parts_needed;
  logic [15:0] words_done;

  always_comb begin
    unique case (rom_width)
      bel_pkg::ROM_W8_CODE:  parts_needed = 2'd3;
      bel_pkg::ROM_W16_CODE: parts_needed = 2'd1;
      default:               parts_needed = 2'd0;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state       <= bel_pkg::ST_RESET;
      src_addr    <= 32'h0000_0000;
      dst_addr    <= bel_pkg::BOOT_DEST_ADDR;
      pack        <= 32'h0000_0000;
      part        <= 2'd0;
      words_done  <= 16'h0000;
      rom_rd_req  <= 1'b0;
      mem_wr_req  <= 1'b0;
      mem_wr_addr <= 32'h0000_0000;
      mem_wr_data <= 32'h0000_0000;
    end else begin
      mem_wr_req <= 1'b0;
      unique case (state)
        bel_pkg::ST_RESET: begin
          if (cfg_valid) begin
            if (boot_mode == bel_pkg::BOOT_ROM_CODE) begin
              state      <= bel_pkg::ST_COPY;
              rom_rd_req <= 1'b1;
            end else begin
              state <= bel_pkg::ST_HOLD;
            end
          end
        end
        bel_pkg::ST_HOLD: begin
          // Host or emulator sets the bit to free the CPU
          if (host_to_cpu_interrupt && boot_mode != bel_pkg::BOOT_ROM_CODE) begin
            state <= bel_pkg::ST_RUN;
          end
        end
        bel_pkg::ST_COPY: begin
          if (words_done == 16'(WORDS)) begin
            // Last word goes out this cycle, so the block transfer is done
            state <= bel_pkg::ST_RUN;
          end else if (rom_rd_valid) begin
            // Narrow parts fill from the low end upward, whatever the endian mode
            unique case (rom_width)
              bel_pkg::ROM_W8_CODE:
                pack <= {rom_rd_data[7:0], pack[31:8]};
              bel_pkg::ROM_W16_CODE:
                pack <= {rom_rd_data[15:0], pack[31:16]};
              default:
                pack <= rom_rd_data;
            endcase
            src_addr <= src_addr + 32'd1;
            if (part == parts_needed) begin
              part       <= 2'd0;
              state      <= bel_pkg::ST_WAIT;
              rom_rd_req <= 1'b0;
            end else begin
              part <= part + 2'd1;
            end
          end
        end
        bel_pkg::ST_WAIT: begin
          mem_wr_req  <= 1'b1;
          mem_wr_addr <= dst_addr;
          mem_wr_data <= pack;
          dst_addr    <= dst_addr + 32'd4;
          words_done  <= words_done + 16'd1;
          state       <= bel_pkg::ST_COPY;
          // No further reads once the last word is in flight
          if (words_done != 16'(WORDS - 1)) begin
            rom_rd_req <= 1'b1;
          end
        end
        bel_pkg::ST_RUN: begin
          state <= bel_pkg::ST_RUN;
        end
        default: begin
          state <= bel_pkg::ST_RESET;
        end
      endcase
    end
  end

  assign rom_rd_addr = src_addr;

  // One-cycle start pulse on leaving the stall
  logic run_q;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      run_q <= 1'b0;
    end else begin
      run_q <= (state == bel_pkg::ST_RUN);
    end
  end

  assign cpu_stall       = (state != bel_pkg::ST_RUN);
  assign cpu_start       = (state == bel_pkg::ST_RUN) && !run_q;
  assign cpu_start_addr  = bel_pkg::START_ADDR;
  assign host_mem_access = (state == bel_pkg::ST_HOLD);

  ////////////////////////////////////////////////////////////////////////////
  // Lane placement of outgoing data

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      external_data_lanes <= 32'h0000_0000;
      lane_strobe         <= 4'h0;
    end else begin
      unique case (acc_width)
        bel_pkg::ACC_W8: begin
          if (!narrow_lane_correction || little_order_mode) begin
            external_data_lanes <= {24'h000000, core_wr_data[7:0]};
            lane_strobe         <= 4'h1;
          end else begin
            external_data_lanes <= {core_wr_data[7:0], 24'h000000};
            lane_strobe         <= 4'h8;
          end
        end
        bel_pkg::ACC_W16: begin
          if (!narrow_lane_correction || little_order_mode) begin
            external_data_lanes <= {16'h0000, core_wr_data[15:0]};
            lane_strobe         <= 4'h3;
          end else begin
            external_data_lanes <= {core_wr_data[15:0], 16'h0000};
            lane_strobe         <= 4'hc;
          end
        end
        default: begin
          external_data_lanes <= core_wr_data;
          lane_strobe         <= 4'hf;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave, zero wait states

  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  always_comb begin
    unique case (paddr)
      bel_pkg::CTRL_OFFSET:   prdata = {31'h0, host_to_cpu_interrupt};
      bel_pkg::STATUS_OFFSET: prdata = {27'h0, cpu_int_pending, host_mem_access,
                                        cfg_valid, cpu_stall, state == bel_pkg::ST_RUN};
      bel_pkg::CONFIG_OFFSET: prdata = {24'h0, rom_width, boot_mode,
                                        2'h0, narrow_lane_correction, little_order_mode};
      default:                prdata = 32'h0000_0000;
    endcase
  end

endmodule : bel_boot_lane

// file: sim/bel_rom_model.sv
// Boot ROM model answering the copy reads
`timescale 1ns/1ps
module bel_rom_model (
  input  wire logic        clk,
  input  wire logic        slow,
  input  wire logic        rom_rd_req,
  input  wire logic [31:0] rom_rd_addr,
  output logic             rom_rd_valid,
  output logic [31:0]      rom_rd_data
);
  logic [31:0] pat;
  // Each byte repeats on every lane, so the image reads alike in either order
  assign pat = {4{rom_rd_addr[7:0] ^ 8'ha5}};
  // Idle data is inverted so a stale unit never passes for a fresh one
  assign rom_rd_data = rom_rd_valid ? pat : ~pat;
  always_ff @(posedge clk) begin
    rom_rd_valid <= rom_rd_req && !(slow && rom_rd_valid);
  end
endmodule : bel_rom_model

// file: sim/bel_boot_lane_sva.sv
// Checker for boot release and lane placement
`timescale 1ns/1ps
module bel_boot_lane_sva #(
  parameter int ROM_BYTES = bel_pkg::ROM_COPY_BYTES
) (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        cpu_stall,
  input wire logic        cpu_start,
  input wire logic [31:0] cpu_start_addr,
  input wire logic        cpu_int_pending,
  input wire logic        host_mem_access,
  input wire logic        little_order_mode,
  input wire logic        narrow_lane_correction,
  input wire logic        rom_rd_req,
  input wire logic        mem_wr_req,
  input wire logic [31:0] mem_wr_addr,
  input wire logic [1:0]  acc_width,
  input wire logic [31:0] core_wr_data,
  input wire logic [31:0] external_data_lanes,
  input wire logic [3:0]  lane_strobe
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic top;
  assign top = !little_order_mode && narrow_lane_correction;
  sequence s_stall_end;
    cpu_stall ##1 !cpu_stall;
  endsequence
  sequence s_one_pulse;
    cpu_start ##1 !cpu_start;
  endsequence
  chk_reset_holds: assert property (disable iff (1'b0) reset |-> cpu_stall && !cpu_start)
    else $error("reset does not hold the cpu");
  chk_release_pulse: assert property (s_stall_end |-> s_one_pulse)
    else $error("release without a single start pulse");
  chk_start_zero: assert property (cpu_start |-> cpu_start_addr == 32'h0)
    else $error("start address not zero");
  chk_stall_no_pend: assert property (cpu_stall |-> !cpu_int_pending)
    else $error("interrupt pending while stalled");
  chk_copy_stalled: assert property (rom_rd_req |-> cpu_stall && !host_mem_access)
    else $error("rom read while cpu runs");
  chk_copy_range: assert property (mem_wr_req |-> cpu_stall
    && mem_wr_addr < ROM_BYTES && mem_wr_addr[1:0] == 2'h0)
    else $error("copy write out of range");
  chk_lane_low8: assert property (acc_width == 2'h0 && !top
    |=> lane_strobe == 4'h1 && external_data_lanes[7:0] == $past(core_wr_data[7:0]))
    else $error("byte not on lowest lane");
  chk_lane_top8: assert property (acc_width == 2'h0 && top
    |=> lane_strobe == 4'h8 && external_data_lanes[31:24] == $past(core_wr_data[7:0]))
    else $error("byte not on top lane");
  chk_lane_half: assert property (acc_width == 2'h1
    |=> lane_strobe == ($past(top) ? 4'hc : 4'h3))
    else $error("half on wrong lanes");
  chk_lane_word: assert property (acc_width == 2'h2 |=> lane_strobe == 4'hf
    && external_data_lanes == $past(core_wr_data))
    else $error("word not on all lanes");
endmodule : bel_boot_lane_sva
bind bel_boot_lane bel_boot_lane_sva #(.ROM_BYTES(ROM_BYTES)) u_sva (.clk, .reset, .cpu_stall,
  .cpu_start, .cpu_start_addr, .cpu_int_pending, .host_mem_access, .little_order_mode,
  .narrow_lane_correction, .rom_rd_req, .mem_wr_req, .mem_wr_addr, .acc_width, .core_wr_data,
  .external_data_lanes, .lane_strobe);

// file: sim/bel_boot_lane_bench.sv
// Testbench for the boot and lane configuration block
`timescale 1ns/1ps
module bel_boot_lane_bench;
  logic        clk, reset, endian_select_strap, lane_correction_strap, host_to_cpu_set, slow;
  logic        psel, penable, pwrite, pready, pslverr, cpu_stall, cpu_start, cpu_int_pending;
  logic        host_mem_access, little_order_mode, narrow_lane_correction, rom_rd_req;
  logic        rom_rd_valid, mem_wr_req;
  logic [1:0]  boot_mode_strap, rom_width_strap, acc_width, cur_w;
  logic [7:0]  paddr;
  logic [3:0]  lane_strobe;
  logic [31:0] pwdata, prdata, cpu_start_addr, rom_rd_addr, rom_rd_data, mem_wr_addr, q;
  logic [31:0] mem_wr_data, core_wr_data, external_data_lanes;
  int          failures = 0, compares = 0, wr_cnt = 0, starts = 0;
  bel_boot_lane #(.ROM_BYTES(16)) dut (.clk, .reset, .endian_select_strap,
    .lane_correction_strap, .boot_mode_strap, .rom_width_strap, .host_to_cpu_set, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .cpu_stall, .cpu_start,
    .cpu_start_addr, .cpu_int_pending, .host_mem_access, .little_order_mode,
    .narrow_lane_correction, .rom_rd_req, .rom_rd_addr, .rom_rd_valid, .rom_rd_data,
    .mem_wr_req, .mem_wr_addr, .mem_wr_data, .acc_width, .core_wr_data,
    .external_data_lanes, .lane_strobe);
  bel_rom_model rom (.clk, .slow, .rom_rd_req, .rom_rd_addr, .rom_rd_valid, .rom_rd_data);
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task conclude;
    $display("failures %0d compares %0d", failures, compares);
    if (failures == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : chk
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'h1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    q = prdata;
    chk({31'h0, pslverr}, 32'h0, "slave error");
    psel <= 1'h0; penable <= 1'h0;
    if (n >= 20) begin
      failures++;
      conclude;
    end
  endtask : apb
  task boot(input logic [1:0] m, input logic [1:0] w, input logic lit, input logic cor);
    @(posedge clk);
    reset <= 1'h1; boot_mode_strap <= m; rom_width_strap <= w; cur_w <= w;
    endian_select_strap <= lit; lane_correction_strap <= cor; slow <= (w != 2'h1);
    repeat (8) @(posedge clk);
    reset <= 1'h0; wr_cnt = 0; starts = 0;
    @(posedge clk);
  endtask : boot
  task wait_run;
    int n;
    n = 0;
    while (cpu_stall !== 1'h0 && n < 500) begin
      @(posedge clk); #1;
      n++;
    end
    if (n >= 500) begin
      failures++;
      conclude;
    end
    // The start pulse is counted one edge after the stall falls
    @(posedge clk); #1;
    chk(cpu_start_addr, 32'h0, "start address");
  endtask : wait_run
  task set_pulse;
    @(posedge clk) host_to_cpu_set <= 1'h1;
    @(posedge clk) host_to_cpu_set <= 1'h0;
  endtask : set_pulse
  task lanes(input logic lit, input logic cor);
    logic [31:0] m;
    int sh;
    for (int w = 0; w < 3; w++) begin
      @(posedge clk);
      acc_width <= 2'(w); core_wr_data <= 32'h1234_5678;
      @(posedge clk); #1;
      sh = (!lit && cor && w < 2) ? (w == 0 ? 24 : 16) : 0;
      m = (w == 0 ? 32'hff : w == 1 ? 32'hffff : 32'hffff_ffff) << sh;
      chk({28'h0, lane_strobe}, {28'h0, m[31], m[23], m[15], m[7]}, "strobe");
      chk(external_data_lanes & m, 32'h1234_5678 << sh & m, "lanes");
    end
  endtask : lanes
  function automatic logic [7:0] rb(input int a);
    return 8'(a) ^ 8'ha5;
  endfunction : rb
  function automatic logic [31:0] exp_word(input int k);
    case (cur_w)
      2'h0: return {rb(4 * k + 3), rb(4 * k + 2), rb(4 * k + 1), rb(4 * k)};
      2'h1: return {rb(2 * k + 1), rb(2 * k + 1), rb(2 * k), rb(2 * k)};
      default: return {4{rb(k)}};
    endcase
  endfunction : exp_word
  always @(posedge clk) begin
    if (cpu_start === 1'h1) starts++;
    if (mem_wr_req === 1'h1) begin
      chk(mem_wr_addr, wr_cnt * 4, "copy address");
      chk(mem_wr_data, exp_word(wr_cnt), "copy word");
      wr_cnt++;
    end
  end
  initial begin
    reset = 1'h1; psel = 1'h0; penable = 1'h0; pwrite = 1'h0; paddr = 8'h0; pwdata = 32'h0;
    host_to_cpu_set = 1'h0; acc_width = 2'h0; core_wr_data = 32'h0; slow = 1'h0; cur_w = 2'h0;
    endian_select_strap = 1'h1; lane_correction_strap = 1'h1;
    boot_mode_strap = 2'h0; rom_width_strap = 2'h0;
    boot(bel_pkg::BOOT_HOST_CODE, bel_pkg::ROM_W8_CODE, 1'h1, 1'h1);
    chk(little_order_mode, 1'h1, "little mode");
    apb(1'h0, bel_pkg::STATUS_OFFSET, 32'h0);
    chk(q & 32'h1f, 32'h0e, "host hold status");
    apb(1'h0, bel_pkg::CONFIG_OFFSET, 32'h0);
    chk(q & 32'hf3, 32'h03, "latched config");
    lanes(1'h1, 1'h1);
    apb(1'h1, bel_pkg::CTRL_OFFSET, 32'h1);
    wait_run;
    chk(starts, 1, "one start");
    chk(cpu_int_pending, 1'h0, "no latch in stall");
    set_pulse;
    repeat (3) @(posedge clk); #1;
    chk(cpu_int_pending, 1'h0, "repeat absorbed");
    apb(1'h1, bel_pkg::CTRL_OFFSET, 32'h2);
    apb(1'h0, bel_pkg::CTRL_OFFSET, 32'h0);
    chk(q & 32'h1, 32'h0, "bit cleared");
    set_pulse;
    repeat (3) @(posedge clk); #1;
    chk(cpu_int_pending, 1'h1, "fresh interrupt");
    apb(1'h0, 8'h40, 32'h0);
    chk(q, 32'h0, "unmapped read");
    boot(bel_pkg::BOOT_EMU_CODE, bel_pkg::ROM_W8_CODE, 1'h0, 1'h1);
    lanes(1'h0, 1'h1);
    set_pulse;
    wait_run;
    chk(starts, 1, "emulator start");
    // Left running on purpose: the next boot resets it in mid-run
    boot(bel_pkg::BOOT_HOST_CODE, bel_pkg::ROM_W16_CODE, 1'h0, 1'h0);
    lanes(1'h0, 1'h0);
    for (int w = 0; w < 3; w++) begin
      boot(bel_pkg::BOOT_ROM_CODE, 2'(w), 1'h1, 1'h1);
      apb(1'h1, bel_pkg::CTRL_OFFSET, 32'h1);
      chk(cpu_stall, 1'h1, "rom boot ignores bit");
      wait_run;
      chk(wr_cnt, 4, "word count");
      chk(starts, 1, "rom start");
    end
    conclude;
  end
  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    conclude;
  end
endmodule : bel_boot_lane_bench
